// ### inc/sqch_pkg.sv
/*
 * Shared constants for the subcode Q-channel handshake: clock rate,
 * handshake timing, subcode frame layout, sync code words and CRC.
 * Assumes a single 40 MHz core clock on both ends of the link.
 */
package sqch_pkg;

   // ***************************************************************
   // Clock and timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS   = 25;        // Core clock period
   localparam int CLK_MHZ         = 40;        // Core clock rate
   localparam int ACK_TIME_US     = 10800;     // Longest acknowledge
   localparam int HOLD_TIME_US    = 2300;      // Least data hold after
   localparam int SCL_HALF_NS     = 750;       // Least shift clock phase
   // Longest time rounds down, least times round up
   localparam int ACK_CYCLES      = ACK_TIME_US * CLK_MHZ;
   localparam int HOLD_CYCLES     = HOLD_TIME_US * CLK_MHZ;
   localparam int SCL_HALF_CYCLES =
      (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W         = 20;        // Wide enough for both

   // ***************************************************************
   // Subcode frame layout
   // ***************************************************************
   localparam logic [13:0] SYNC_CODE_0  = 14'h0801; // Frame sync word 0
   localparam logic [13:0] SYNC_CODE_1  = 14'h0012; // Frame sync word 1
   localparam int          P_BIT_POS    = 7;        // Pause bit in symbol
   localparam int          Q_BIT_POS    = 6;        // Q bit in symbol
   localparam logic [6:0]  Q_LAST_BIT   = 7'h5F;    // 96 bits per frame
   localparam logic [6:0]  Q_DATA_BITS  = 7'h50;    // 80 bits before CRC
   localparam int          Q_OUT_BITS   = 80;       // Bits shifted out
   localparam logic [15:0] CRC_POLY     = 16'h1021; // x16+x12+x5+1
   localparam logic [15:0] CRC_INIT     = 16'h0000; // CRC start value
   localparam logic [1:0]  PAUSE_LAST   = 2'h2;     // Three equal samples
   localparam int          BUF_DEPTH    = 2;        // Symbol buffer depth

endpackage : sqch_pkg

// ### inc/sqch_link_if.sv
/*
 * Wires between the decoder end and the host end of the Q-channel link.
 * Assumes both ends drive only the enables and constant-low outputs of
 * the shared request/acknowledge line; the pull-up is resolved here.
 */
`timescale 1ns/100ps
interface sqch_link_if;
   logic reqAckDevOut;   // Decoder output value, always low
   logic reqAckDevOe;    // Decoder pulls the line low
   logic reqAckHostOut;  // Host output value, always low
   logic reqAckHostOe;   // Host pulls the line low
   logic reqAckLevel;    // Resolved line level
   logic shiftClk;       // Shift clock, host driven
   logic serialOut;      // Serial data from the decoder
   logic serialOe;       // Serial data output enabled

   // Pull-up: a line nobody pulls low reads high (see RULE_03)
   assign reqAckLevel = !((reqAckDevOe & !reqAckDevOut) |
                          (reqAckHostOe & !reqAckHostOut));

   modport dev  (output reqAckDevOut, reqAckDevOe, serialOut, serialOe,
                 input  reqAckLevel, shiftClk);
   modport host (output reqAckHostOut, reqAckHostOe, shiftClk,
                 input  reqAckLevel, serialOut, serialOe);
endinterface : sqch_link_if

// ### design/sqch_host.sv
/*
 * Host end: requests one Q-channel frame, clocks it in and ends the
 * transfer. Assumes the link interface resolves the shared line.
 */
`timescale 1ns/100ps
module sqch_host
   import sqch_pkg::*;
#(
   parameter int NUM_BITS = 80          // Bits taken per transfer, 1..80
)(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   sqch_link_if.host                  link,
   input  wire logic                  readReq,  // Start a read, pulse
   input  wire logic                  holdReq,  // Hold clock low, level
   output logic [sqch_pkg::Q_OUT_BITS-1:0] rxBits,
   output logic                       rxValid,  // Frame taken, pulse
   output logic                       busy      // Transfer running
);
   import sqch_pkg::*;

   // ***************************************************************
   // State and registers
   // ***************************************************************
   typedef enum {H_IDLE, H_WAIT, H_LOW, H_HIGH} sqch_hstate_t;
   sqch_hstate_t            state_q, state_d;   // Host phase
   logic                    lineMeta_q, lineSync_q; // Line synchroniser
   logic                    datMeta_q, datSync_q;   // Data synchroniser
   logic                    oe_q, oe_d;         // Host pulls line low
   logic                    scl_q, scl_d;       // Shift clock out
   logic                    seenHigh_q, seenHigh_d; // Line released seen
   logic [7:0]              div_q, div_d;       // Clock phase divider
   logic [6:0]              cnt_q, cnt_d;       // Bits taken
   logic [Q_OUT_BITS-1:0]   rx_q, rx_d;         // Received bits
   logic                    valid_q, valid_d;   // Done pulse
   logic                    divEnd;             // Phase time elapsed

   assign link.reqAckHostOe  = oe_q;
   assign link.shiftClk      = scl_q;
   assign rxBits             = rx_q;
   assign rxValid            = valid_q;
   assign busy               = (state_q != H_IDLE);
   assign divEnd             = (div_q == 8'(SCL_HALF_CYCLES - 1));

   // ***************************************************************
   // Next state
   // ***************************************************************
   // Clock phases last at least the documented low and high times
   always_comb
   begin
      state_d    = state_q;
      oe_d       = oe_q;
      scl_d      = scl_q;
      seenHigh_d = seenHigh_q;
      div_d      = divEnd ? 8'h00 : div_q + 8'h01;
      cnt_d      = cnt_q;
      rx_d       = rx_q;
      valid_d    = 1'b0;
      case (state_q)
         H_IDLE:
         begin
            oe_d = 1'b1;                          // see RULE_01
            if (readReq)
            begin
               oe_d       = 1'b0;                 // see RULE_02
               seenHigh_d = 1'b0;
               cnt_d      = 7'h00;
               state_d    = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // Own drive takes two cycles to leave the synchroniser
            if (lineSync_q)
               seenHigh_d = 1'b1;
            if (seenHigh_q && !lineSync_q)
            begin
               scl_d   = 1'b0;                    // see RULE_06
               div_d   = 8'h00;
               state_d = H_LOW;
            end
         end
         H_LOW:
         begin
            // Holding the clock low keeps the frame frozen
            if (holdReq)                          // see RULE_13
               div_d = 8'h00;
            else if (divEnd)
            begin
               scl_d   = 1'b1;
               rx_d    = {rx_q[Q_OUT_BITS-2:0], datSync_q}; // see RULE_17
               cnt_d   = cnt_q + 7'h01;
               state_d = H_HIGH;
            end
         end
         H_HIGH:
         begin
            if (divEnd)
            begin
               if (cnt_q == 7'(NUM_BITS))
               begin
                  oe_d    = 1'b1;                 // see RULE_08
                  valid_d = 1'b1;
                  state_d = H_IDLE;
               end
               else
               begin
                  scl_d   = 1'b0;
                  state_d = H_LOW;
               end
            end
         end
         default:
            state_d = H_IDLE;
      endcase
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_q    <= H_IDLE;
         lineMeta_q <= 1'b0;
         lineSync_q <= 1'b0;
         datMeta_q  <= 1'b0;
         datSync_q  <= 1'b0;
         oe_q       <= 1'b1;
         scl_q      <= 1'b1;
         seenHigh_q <= 1'b0;
         div_q      <= 8'h00;
         cnt_q      <= 7'h00;
         rx_q       <= '0;
         valid_q    <= 1'b0;
         link.reqAckHostOut <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         lineMeta_q <= link.reqAckLevel;
         lineSync_q <= lineMeta_q;
         datMeta_q  <= link.serialOut;
         datSync_q  <= datMeta_q;
         oe_q       <= oe_d;
         scl_q      <= scl_d;
         seenHigh_q <= seenHigh_d;
         div_q      <= div_d;
         cnt_q      <= cnt_d;
         rx_q       <= rx_d;
         valid_q    <= valid_d;
         link.reqAckHostOut <= 1'b0;
      end
   end

endmodule : sqch_host

// ### design/sqch_device.sv
/*
 * Decoder end: collects subcode Q-channel frames, checks their CRC and
 * hands one frozen frame to the host over the request/acknowledge link.
 * Assumes subcode symbols arrive on core_clk with their 14-bit code
 * words; shift clock and line level come from outside and are synced.
 */
// Summary of operation
// RULE_01: Host holds line low when idle
// RULE_02: Host requests by releasing the line
// RULE_03: Line pulled up; device only pulls low
// RULE_04: Collect always; freeze first good frame (code stalls collection in ST_SHIFT)
// RULE_05: Acknowledge low and enable serial output
// RULE_06: Host clocks data after acknowledge
// RULE_07: First falling clock edge releases acknowledge
// RULE_08: Host ends transfer by pulling low
// RULE_09: End disables output, resumes collecting
// RULE_10: No clock within 10.8 ms withdraws acknowledge
// RULE_11: Frozen frame kept 2.3 ms after withdrawal
// RULE_12: Next good frame gives fresh acknowledge
// RULE_13: Clock held low suppresses refresh
// RULE_14: Access time grows per failed frame
// RULE_15: Two code words mark frame sync
// RULE_16: Pause bit of sync symbol ignored
// RULE_17: Data changes on fall, sampled on rise
`timescale 1ns/100ps
module sqch_device
   import sqch_pkg::*;
#(
   parameter int ACK_CYC  = sqch_pkg::ACK_CYCLES,  // Acknowledge timeout
   parameter int HOLD_CYC = sqch_pkg::HOLD_CYCLES, // Hold after timeout
   parameter int DEPTH    = sqch_pkg::BUF_DEPTH    // Symbol buffer depth
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   sqch_link_if.dev         link,
   input  wire logic        symValid,  // Symbol offered
   output logic             symReady,  // Buffer can take a symbol
   input  wire logic [13:0] symCode,   // Channel code word
   input  wire logic [7:0]  symData,   // Demodulated symbol P..W
   output logic             pauseFlag, // Debounced pause bit
   output logic             frameOk    // Good frame seen, pulse
);
   import sqch_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width
   localparam int CW = $clog2(DEPTH + 1);               // Count width

   // ***************************************************************
   // Declarations
   // ***************************************************************
   typedef enum {ST_COLLECT, ST_ACK, ST_SHIFT, ST_HOLD} sqch_state_t;
   sqch_state_t          state_q, state_d;     // Handshake phase
   logic [21:0]          mem_q [DEPTH];        // Code word and symbol
   logic [21:0]          mem_d [DEPTH];
   logic [PW-1:0]        wr_q, wr_d, rd_q, rd_d; // Buffer pointers
   logic [CW-1:0]        cnt_q, cnt_d;         // Buffer fill
   logic                 rdy_q, rdy_d;         // Ready, registered
   logic                 reqMeta_q, req_q;     // Line synchroniser
   logic                 sclMeta_q, scl_q;     // Clock synchroniser
   logic                 sclPrev_q;            // Edge finder
   logic [6:0]           bit_q, bit_d;         // Bit in Q frame
   logic [95:0]          qBits_q, qBits_d;     // Gathered Q bits
   logic [15:0]          crc_q, crc_d;         // Running CRC
   logic                 pCand_q, pCand_d;     // Pause candidate
   logic [1:0]           pCnt_q, pCnt_d;       // Equal pause samples
   logic                 pause_q, pause_d;     // Debounced pause
   logic                 ok_q, ok_d;           // Good frame pulse
   logic [Q_OUT_BITS-1:0] out_q, out_d;        // Frozen frame shifter
   logic                 ser_q, ser_d;         // Serial data pin
   logic                 serOe_q, serOe_d;     // Serial enable
   logic                 ackOe_q, ackOe_d;     // Pull line low
   logic                 seenHigh_q, seenHigh_d; // Release seen
   logic [TIMER_W-1:0]   tmr_q, tmr_d;         // Ack and hold timer
   logic                 push, pop, isSync, qBit, pBit, done, good;
   logic                 sclFall;              // Shift clock fell
   logic [21:0]          head;                 // Oldest symbol
   logic [95:0]          qNew;                 // Frame with newest bit

   assign symReady         = rdy_q;
   assign pauseFlag        = pause_q;
   assign frameOk          = ok_q;
   assign link.serialOut   = ser_q;
   assign link.serialOe    = serOe_q;
   assign link.reqAckDevOe = ackOe_q;
   assign sclFall          = sclPrev_q & !scl_q;

   // ***************************************************************
   // Next state: buffer, collector and handshake
   // ***************************************************************
   always_comb
   begin
      state_d = state_q;
      mem_d   = mem_q;
      wr_d    = wr_q;
      rd_d    = rd_q;
      cnt_d   = cnt_q;
      bit_d   = bit_q;
      qBits_d = qBits_q;
      crc_d   = crc_q;
      pCand_d = pCand_q;
      pCnt_d  = pCnt_q;
      pause_d = pause_q;
      out_d   = out_q;
      serOe_d = serOe_q;
      ackOe_d = ackOe_q;
      seenHigh_d = seenHigh_q;
      tmr_d   = tmr_q;
      done    = 1'b0;
      good    = 1'b0;
      head    = mem_q[rd_q];
      qBit    = head[Q_BIT_POS];
      pBit    = head[P_BIT_POS];
      qNew    = {qBits_q[94:0], qBit};
      isSync  = (head[21:8] == SYNC_CODE_0) ||
                (head[21:8] == SYNC_CODE_1);          // see RULE_15
      // Collector stalls while the host shifts, so the buffer fills
      push = symValid & rdy_q;
      pop  = (cnt_q != '0) && (state_q != ST_SHIFT);
      if (push)
      begin
         mem_d[wr_q] = {symCode, symData};
         wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      if (pop)
         rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      if (push && !pop)
         cnt_d = cnt_q + CW'(1);
      else if (pop && !push)
         cnt_d = cnt_q - CW'(1);
      rdy_d = (cnt_d != CW'(DEPTH));

      // Q-channel collection runs in every handshake phase except ST_SHIFT
      if (pop)
      begin
         if (isSync)
         begin
            bit_d = 7'h00;                            // see RULE_15
            crc_d = CRC_INIT;
         end
         else
         begin
            // Pause debounced on data symbols only  -- see RULE_16
            if (pBit == pCand_q)
            begin
               if (pCnt_q >= PAUSE_LAST - 2'h1)
                  pause_d = pBit;
               else
                  pCnt_d = pCnt_q + 2'h1;
            end
            else
            begin
               pCand_d = pBit;
               pCnt_d  = 2'h0;
            end
            qBits_d = qNew;
            if (bit_q < Q_DATA_BITS)
               crc_d = {crc_q[14:0], 1'b0} ^
                       ((crc_q[15] ^ qBit) ? CRC_POLY : 16'h0000);
            if (bit_q == Q_LAST_BIT)
            begin
               done  = 1'b1;
               bit_d = 7'h00;
               good  = (crc_q == ~qNew[15:0]);        // Stored inverted
            end
            else
               bit_d = bit_q + 7'h01;
         end
      end
      ok_d = done & good;

      case (state_q)
         ST_COLLECT:
         begin
            // First good frame after a seen request is frozen at once
            if (done && good && req_q)          // see RULE_04 RULE_14
            begin
               out_d   = qNew[95:16];
               ackOe_d = 1'b1;                        // see RULE_05
               serOe_d = 1'b1;
               tmr_d   = '0;
               state_d = ST_ACK;
            end
         end
         ST_ACK:
         begin
            tmr_d = tmr_q + TIMER_W'(1);
            if (sclFall)
            begin
               ackOe_d    = 1'b0;                     // see RULE_07
               seenHigh_d = 1'b0;
               state_d    = ST_SHIFT;
            end
            else if (tmr_q == TIMER_W'(ACK_CYC - 1))
            begin
               ackOe_d    = 1'b0;                     // see RULE_10
               seenHigh_d = 1'b0;
               tmr_d      = '0;
               state_d    = ST_HOLD;
            end
         end
         ST_SHIFT:
         begin
            // Fall after the first moves to the next bit
            if (sclFall)
               out_d = {out_q[Q_OUT_BITS-2:0], 1'b0}; // see RULE_17
            // Own pull-down lingers in the synchroniser; wait for high
            if (req_q)
               seenHigh_d = 1'b1;
            if (seenHigh_q && !req_q)
            begin
               serOe_d = 1'b0;                        // see RULE_09
               state_d = ST_COLLECT;
            end
         end
         ST_HOLD:
         begin
            if (tmr_q != TIMER_W'(HOLD_CYC - 1))
               tmr_d = tmr_q + TIMER_W'(1);
            if (req_q)
               seenHigh_d = 1'b1;
            if (sclFall)
               state_d = ST_SHIFT;                    // see RULE_11
            else if (seenHigh_q && !req_q)
            begin
               serOe_d = 1'b0;
               state_d = ST_COLLECT;
            end
            // Clock held low keeps this frame; else refresh
            else if (tmr_q == TIMER_W'(HOLD_CYC - 1) && scl_q)
            begin
               serOe_d = 1'b0;                        // see RULE_13
               state_d = ST_COLLECT;                  // see RULE_12
            end
         end
         default:
            state_d = ST_COLLECT;
      endcase
      ser_d = out_d[Q_OUT_BITS-1];
   end

   // ***************************************************************
   // Symbol storage, no reset needed
   // ***************************************************************
   always_ff @(posedge core_clk)
   begin
      mem_q <= mem_d;
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_q    <= ST_COLLECT;
         wr_q       <= '0;
         rd_q       <= '0;
         cnt_q      <= '0;
         rdy_q      <= 1'b0;
         reqMeta_q  <= 1'b0;
         req_q      <= 1'b0;
         sclMeta_q  <= 1'b1;
         scl_q      <= 1'b1;
         sclPrev_q  <= 1'b1;
         bit_q      <= 7'h00;
         qBits_q    <= '0;
         crc_q      <= CRC_INIT;
         pCand_q    <= 1'b0;
         pCnt_q     <= 2'h0;
         pause_q    <= 1'b0;
         ok_q       <= 1'b0;
         out_q      <= '0;
         ser_q      <= 1'b0;
         serOe_q    <= 1'b0;
         ackOe_q    <= 1'b0;
         seenHigh_q <= 1'b0;
         tmr_q      <= '0;
         link.reqAckDevOut <= 1'b0;                   // see RULE_03
      end
      else
      begin
         state_q    <= state_d;
         wr_q       <= wr_d;
         rd_q       <= rd_d;
         cnt_q      <= cnt_d;
         rdy_q      <= rdy_d;
         reqMeta_q  <= link.reqAckLevel;
         req_q      <= reqMeta_q;
         sclMeta_q  <= link.shiftClk;
         scl_q      <= sclMeta_q;
         sclPrev_q  <= scl_q;
         bit_q      <= bit_d;
         qBits_q    <= qBits_d;
         crc_q      <= crc_d;
         pCand_q    <= pCand_d;
         pCnt_q     <= pCnt_d;
         pause_q    <= pause_d;
         ok_q       <= ok_d;
         out_q      <= out_d;
         ser_q      <= ser_d;
         serOe_q    <= serOe_d;
         ackOe_q    <= ackOe_d;
         seenHigh_q <= seenHigh_d;
         tmr_q      <= tmr_d;
         link.reqAckDevOut <= 1'b0;
      end
   end

endmodule : sqch_device

// ### testbench/sqch_link_asserts.sv
/*
 * Checker on the link between decoder end and host end.
 * Assumes one core clock and the pull-up resolved in the link.
 */
`timescale 1ns/100ps
module sqch_link_asserts #(
   parameter int ACK_CYC = 400     // Acknowledge timeout in cycles
)(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reqAckDevOut,
   input wire logic reqAckDevOe,
   input wire logic reqAckHostOut,
   input wire logic reqAckHostOe,
   input wire logic reqAckLevel,
   input wire logic shiftClk,
   input wire logic serialOut,
   input wire logic serialOe
);
   logic [19:0] ackCnt_q;          // Cycles acknowledge has stood

   // Counter avoids a long repetition the tools would unroll
   always_ff @(posedge core_clk)
      ackCnt_q <= (!rst_n || !reqAckDevOe) ? 20'h0 : ackCnt_q + 20'h1;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_DEV_LOW: assert property (reqAckDevOut == 1'b0)
      else $error("device drove the shared line high");
   AST_ACK_OE: assert property ($rose(reqAckDevOe) |-> serialOe)
      else $error("acknowledge without data output");
   AST_OE_HELD: assert property (reqAckDevOe |-> serialOe)
      else $error("data output off during acknowledge");
   AST_ACK_REQ: assert property ($rose(reqAckDevOe) |->
      $past(!reqAckHostOe, 3)) else $error("acknowledge with no request");
   AST_FALL_ACK: assert property ($fell(shiftClk) && reqAckDevOe
      |-> ##[1:8] !reqAckDevOe) else $error("clock fall kept acknowledge");
   AST_TIMEOUT: assert property (ackCnt_q <= ACK_CYC + 1)
      else $error("acknowledge stood too long");
   AST_END_OFF: assert property ($rose(reqAckHostOe) && serialOe
      |-> ##[1:8] !serialOe) else $error("data output stayed on");
   AST_OUT_STEADY: assert property (serialOe && $past(serialOe)
      && $changed(serialOut) |-> !shiftClk)
      else $error("data changed while clock high");
endmodule : sqch_link_asserts

// ### testbench/subcode_q_channel_handshake_tb.sv
/*
 * Bench: decoder and host ends joined, plus a second decoder whose
 * host side the bench drives. Assumes symbols may come back to back.
 */
`timescale 1ns/100ps
module subcode_q_channel_handshake_tb;
   import sqch_pkg::*;
   localparam int ACK = 400;       // Short acknowledge timeout
   localparam int HLD = 100;       // Short data hold
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        symValid = 1'b0;
   logic [13:0] symCode  = 14'h0100;
   logic [7:0]  symData  = 8'h00;
   logic        readReq  = 1'b0;
   logic        holdReq  = 1'b0;
   logic        hostDone = 1'b0;
   logic        rdy1, rdy2, pause1, ok1, rxValid, busy;
   logic [79:0] rxBits, pay;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          nOk = 0;
   int          n, nFr = 0;
   // Both decoders take a symbol only when both can
   wire         symGo = symValid & rdy1 & rdy2;
   sqch_link_if link1 ();
   sqch_link_if link2 ();
   sqch_device #(.ACK_CYC(ACK), .HOLD_CYC(HLD)) sqch_device_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(link1), .symValid(symGo),
      .symReady(rdy1), .symCode(symCode), .symData(symData),
      .pauseFlag(pause1), .frameOk(ok1));
   sqch_device #(.ACK_CYC(ACK), .HOLD_CYC(HLD)) sqch_device_b_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(link2), .symValid(symGo),
      .symReady(rdy2), .symCode(symCode), .symData(symData),
      .pauseFlag(), .frameOk());
   sqch_host sqch_host_i (.core_clk(core_clk), .rst_n(rst_n), .link(link1),
      .readReq(readReq), .holdReq(holdReq), .rxBits(rxBits),
      .rxValid(rxValid), .busy(busy));
   sqch_link_asserts #(.ACK_CYC(ACK)) sqch_link_asserts_i (
      .core_clk(core_clk), .rst_n(rst_n),
      .reqAckDevOut(link1.reqAckDevOut), .reqAckDevOe(link1.reqAckDevOe),
      .reqAckHostOut(link1.reqAckHostOut), .reqAckHostOe(link1.reqAckHostOe),
      .reqAckLevel(link1.reqAckLevel), .shiftClk(link1.shiftClk),
      .serialOut(link1.serialOut), .serialOe(link1.serialOe));

   always #12.5 core_clk = ~core_clk;

   // Cycle ceiling cuts a hang short; good-frame pulses counted
   always @(posedge core_clk)
   begin
      cycles++;
      if (ok1 === 1'b1)
         nOk++;
      if (cycles == 40000)
      begin
         fail_count++;
         close_out();
      end
   end

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   function automatic logic [15:0] crc16(input logic [79:0] d);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 79; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc16

   // Valid stays up between symbols; caller lowers it at the end
   task automatic send_sym(input logic [13:0] code, input logic [7:0] data);
      symCode  = code;
      symData  = data;
      symValid = 1'b1;
      do @(posedge core_clk); while (symGo !== 1'b1);
      @(negedge core_clk);
   endtask : send_sym

   // Sync codes alternate; last two data P bits are inverted
   task automatic send_frame(input logic [79:0] p, input logic bad,
                             input logic pD);
      logic [95:0] q;
      q = {p, ~crc16(p) ^ {15'h0, bad}};
      send_sym(nFr[0] ? SYNC_CODE_1 : SYNC_CODE_0, {~pD, 7'($urandom)});
      for (int i = 95; i >= 0; i--)
         send_sym(14'h0100, {(i < 2) ? ~pD : pD, q[i], 6'($urandom)});
      nFr++;
   endtask : send_frame

   task automatic stream(input logic [79:0] p, input int nBad);
      for (int k = 0; !hostDone; k++)
         send_frame((k < nBad) ? ~p : p, k < nBad, 1'b1);
      symValid = 1'b0;
   endtask : stream

   task automatic read_once(input int nBad, input int holdCyc);
      int t0;
      pay = {$urandom, $urandom, 16'($urandom)};
      holdReq = (holdCyc > 0);
      fork
         stream(pay, nBad);
         begin
            readReq = 1'b1;
            @(negedge core_clk);
            readReq = 1'b0;
            t0 = cycles;
            while (link1.reqAckDevOe !== 1'b1) @(negedge core_clk);
            check(cycles - t0 <= (nBad + 2) * 97 + 20, 1);
            repeat (holdCyc) @(negedge core_clk);
            holdReq = 1'b0;
            while (rxValid !== 1'b1) @(negedge core_clk);
            check(rxBits, pay);
            hostDone = 1'b1;
         end
      join
      repeat (10) @(negedge core_clk);
      check(link1.serialOe, 0);
      hostDone = 1'b0;
      $display("read done, bad frames %0d", nBad);
   endtask : read_once

   initial
   begin
      void'($urandom(32'h3740A487));
      link2.reqAckHostOut = 1'b0;
      link2.reqAckHostOe  = 1'b1;
      link2.shiftClk      = 1'b1;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      // Good, good, bad frame, then a lone sync with P low
      pay = {$urandom, $urandom, 16'($urandom)};
      send_frame(pay, 1'b0, 1'b1);
      send_frame(pay, 1'b0, 1'b1);
      send_frame(pay, 1'b1, 1'b1);
      send_sym(SYNC_CODE_0, 8'h00);
      symValid = 1'b0;
      repeat (4) @(negedge core_clk);
      check(nOk, 2);
      check(pause1, 1);
      $display("sync and pause test done");
      read_once(2, 0);
      read_once(0, 1000);
      // Second decoder: request, never clock, watch the timeout
      pay = {$urandom, $urandom, 16'($urandom)};
      fork
         stream(pay, 0);
         begin
            link2.reqAckHostOe = 1'b0;
            while (link2.reqAckDevOe !== 1'b1) @(negedge core_clk);
            for (n = 0; link2.reqAckDevOe === 1'b1; n++) @(negedge core_clk);
            check(n >= ACK - 1 && n <= ACK + 1, 1);
            for (n = 0; link2.serialOe === 1'b1; n++) @(negedge core_clk);
            check(n >= HLD, 1);
            link2.shiftClk = 1'b0;
            for (n = 0; link2.reqAckDevOe !== 1'b1; n++) @(negedge core_clk);
            check(n <= 2 * 97 + 10, 1);
            repeat (ACK + HLD + 50) @(negedge core_clk);
            check({link2.reqAckDevOe, link2.serialOe}, 1);
            link2.reqAckHostOe = 1'b1;
            hostDone = 1'b1;
         end
      join
      repeat (10) @(negedge core_clk);
      check(link2.serialOe, 0);
      $display("timeout test done");
      close_out();
   end
endmodule : subcode_q_channel_handshake_tb
